// File: hdl/rsc_pkg.sv
// Constants and types shared by the reset sequence controller
package rsc_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned CNT_W = 24;

	// Sequence durations as printed, in their own units
	localparam int unsigned DRB_MIN_MS = 15;
	localparam int unsigned DRB_MAX_MS = 50;
	localparam int unsigned DR_MIN_US = 400;
	localparam int unsigned DR_MAX_US = 2000;
	localparam int unsigned ERLB_MIN_MS = 15;
	localparam int unsigned ERLB_MAX_MS = 50;
	localparam int unsigned FRL_MIN_US = 400;
	localparam int unsigned FRL_MAX_US = 2000;
	localparam int unsigned FRS_MIN_US = 1;
	localparam int unsigned FRS_MAX_US = 500;

	// Cycle counts; all figures divide exactly at 125 MHz
	localparam int unsigned DRB_MIN_CYC = DRB_MIN_MS * 1000 * CLK_MHZ;
	localparam int unsigned DRB_MAX_CYC = DRB_MAX_MS * 1000 * CLK_MHZ;
	localparam int unsigned DR_MIN_CYC = DR_MIN_US * CLK_MHZ;
	localparam int unsigned DR_MAX_CYC = DR_MAX_US * CLK_MHZ;
	localparam int unsigned ERLB_MIN_CYC = ERLB_MIN_MS * 1000 * CLK_MHZ;
	localparam int unsigned ERLB_MAX_CYC = ERLB_MAX_MS * 1000 * CLK_MHZ;
	localparam int unsigned FRL_MIN_CYC = FRL_MIN_US * CLK_MHZ;
	localparam int unsigned FRL_MAX_CYC = FRL_MAX_US * CLK_MHZ;
	localparam int unsigned FRS_MIN_CYC = FRS_MIN_US * CLK_MHZ;
	localparam int unsigned FRS_MAX_CYC = FRS_MAX_US * CLK_MHZ;

	// Lengths of the first two phases; the third phase takes the rest
	localparam logic [CNT_W-1:0] PH1_CYC = 24'h000004;
	localparam logic [CNT_W-1:0] PH2_CYC = 24'h000004;
	localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;

	typedef enum logic [2:0] {
		K_DRB,
		K_DR,
		K_ERLB,
		K_FRL,
		K_FRS
	} rsc_kind_t;

	typedef enum logic [2:0] {
		ST_POR_HOLD,
		ST_PH1,
		ST_PH2,
		ST_PH3,
		ST_EXTEND,
		ST_RUN
	} rsc_state_t;

	typedef struct packed {
		logic inReset;
		logic thirdResetPhase;
		rsc_kind_t kind;
	} rsc_status_t;

	localparam rsc_status_t STATUS_RESET = '{inReset: 1'b1, thirdResetPhase: 1'b0, kind: K_DRB};
endpackage : rsc_pkg

// File: hdl/rsc_seq_timer.sv
// Elapsed-cycle counter for one reset sequence
`timescale 1ns/1ps
module rsc_seq_timer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clear,
	output logic [rsc_pkg::CNT_W-1:0] elapsed
);
	logic [rsc_pkg::CNT_W-1:0] next_elapsed;

	// Saturates so a long external extension cannot wrap back into range
	always_comb begin
		if (clear) begin
			next_elapsed = rsc_pkg::CNT_RESET;
		end else if (&elapsed) begin
			next_elapsed = elapsed;
		end else begin
			next_elapsed = elapsed + 24'h000001;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			elapsed <= rsc_pkg::CNT_RESET;
		end else begin
			elapsed <= next_elapsed;
		end
	end
endmodule : rsc_seq_timer

// File: hdl/rsc_reset_sequencer.sv
// Reset sequencer: five reset sequences, shared open-drain reset line
// Behaviour
// - Destructive reset with self test lasts 15 ms to 50 ms before run mode.
// - Destructive reset without self test lasts 400 us to 2000 us.
// - Long external reset with self test lasts 15 ms to 50 ms.
// - Long functional reset without self test lasts 400 us to 2000 us.
// - Short functional reset lasts 1 us to 500 us.
// - Maximum durations hold only when nobody holds the reset line low.
// - Sequence ends when run mode starts and the first instruction executes.
// - Destructive resets start the regulator self test inside the third phase.
// - Power-on-reset deassertion starts the reset sequence in both regulation modes.
// - Device only pulls the reset line low, never drives it high.
// - Device stays in reset while the line is held low after the third phase.
// - Functional resets drive the line low only when that source is enabled.
`timescale 1ns/1ps
module rsc_reset_sequencer #(
	parameter int unsigned DRB_CYC = rsc_pkg::DRB_MIN_CYC,
	parameter int unsigned DR_CYC = rsc_pkg::DR_MIN_CYC,
	parameter int unsigned ERLB_CYC = rsc_pkg::ERLB_MIN_CYC,
	parameter int unsigned FRL_CYC = rsc_pkg::FRL_MIN_CYC,
	parameter int unsigned FRS_CYC = rsc_pkg::FRS_MIN_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic powerOnResetInput_n,
	input wire logic bistEnable,
	input wire logic destructiveReq,
	input wire logic functionalReq,
	input wire logic functionalShort,
	input wire logic functionalResetPinEnable,
	input wire logic resetLineIn,
	output logic resetLineOut,
	output logic resetLineOe,
	output logic runModeEntry,
	output logic smpsSelfTestStart,
	output rsc_pkg::rsc_status_t status
);
	rsc_pkg::rsc_state_t state;
	rsc_pkg::rsc_state_t next_state;
	rsc_pkg::rsc_kind_t kind;
	rsc_pkg::rsc_kind_t next_kind;
	logic drivePin;
	logic next_drivePin;
	logic next_resetLineOe;
	logic next_runModeEntry;
	logic next_smpsSelfTestStart;
	rsc_pkg::rsc_status_t next_status;
	logic [rsc_pkg::CNT_W-1:0] elapsed;
	logic [rsc_pkg::CNT_W-1:0] target;
	logic timerClear;
	logic extended;
	logic next_extended;

	rsc_seq_timer u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.clear(timerClear),
		.elapsed(elapsed)
	);

	always_comb begin
		case (kind)
			rsc_pkg::K_DRB: target = DRB_CYC[rsc_pkg::CNT_W-1:0];
			rsc_pkg::K_DR: target = DR_CYC[rsc_pkg::CNT_W-1:0];
			rsc_pkg::K_ERLB: target = ERLB_CYC[rsc_pkg::CNT_W-1:0];
			rsc_pkg::K_FRL: target = FRL_CYC[rsc_pkg::CNT_W-1:0];
			rsc_pkg::K_FRS: target = FRS_CYC[rsc_pkg::CNT_W-1:0];
			default: target = DRB_CYC[rsc_pkg::CNT_W-1:0];
		endcase
	end

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_drivePin = drivePin;
		next_runModeEntry = 1'b0;
		next_smpsSelfTestStart = 1'b0;
		next_extended = extended;
		timerClear = 1'b0;
		case (state)
			rsc_pkg::ST_POR_HOLD: begin
				// Supplies are in range once the regulator releases this input
				if (powerOnResetInput_n) begin
					next_state = rsc_pkg::ST_PH1;
					next_kind = bistEnable ? rsc_pkg::K_DRB : rsc_pkg::K_DR;
					next_drivePin = 1'b1;
					timerClear = 1'b1;
				end
			end
			rsc_pkg::ST_PH1: begin
				if (elapsed == rsc_pkg::PH1_CYC - 24'h000001) begin
					next_state = rsc_pkg::ST_PH2;
				end
			end
			rsc_pkg::ST_PH2: begin
				if (elapsed == rsc_pkg::PH1_CYC + rsc_pkg::PH2_CYC - 24'h000001) begin
					next_state = rsc_pkg::ST_PH3;
					// The self test time is spent inside the third phase
					if (kind == rsc_pkg::K_DRB || kind == rsc_pkg::K_DR) begin
						next_smpsSelfTestStart = 1'b1;
					end
				end
			end
			rsc_pkg::ST_PH3: begin
				if (elapsed == target - 24'h000001) begin
					next_state = rsc_pkg::ST_EXTEND;
					next_extended = 1'b0;
				end
			end
			rsc_pkg::ST_EXTEND: begin
				// Line released; an outside generator may still hold it low
				if (resetLineIn) begin
					next_state = rsc_pkg::ST_RUN;
					next_runModeEntry = 1'b1;
				end else begin
					next_extended = 1'b1;
				end
			end
			rsc_pkg::ST_RUN: begin
				if (destructiveReq) begin
					next_state = rsc_pkg::ST_PH1;
					next_kind = bistEnable ? rsc_pkg::K_DRB : rsc_pkg::K_DR;
					next_drivePin = 1'b1;
					timerClear = 1'b1;
				end else if (!resetLineIn) begin
					next_state = rsc_pkg::ST_PH1;
					next_kind = rsc_pkg::K_ERLB;
					next_drivePin = 1'b1;
					timerClear = 1'b1;
				end else if (functionalReq) begin
					next_state = rsc_pkg::ST_PH1;
					next_kind = functionalShort ? rsc_pkg::K_FRS : rsc_pkg::K_FRL;
					next_drivePin = functionalResetPinEnable;
					timerClear = 1'b1;
				end
			end
			default: begin
				next_state = rsc_pkg::ST_POR_HOLD;
			end
		endcase
		// A low power-on-reset input overrides every sequence
		if (!powerOnResetInput_n) begin
			next_state = rsc_pkg::ST_POR_HOLD;
			next_drivePin = 1'b1;
			next_runModeEntry = 1'b0;
			next_smpsSelfTestStart = 1'b0;
			timerClear = 1'b1;
		end
		next_resetLineOe = drivePinActive(next_state, next_drivePin);
		next_status.inReset = (next_state != rsc_pkg::ST_RUN);
		next_status.thirdResetPhase = (next_state == rsc_pkg::ST_PH3);
		next_status.kind = next_kind;
	end

	function automatic logic drivePinActive(input rsc_pkg::rsc_state_t st, input logic en);
		drivePinActive = en && (st == rsc_pkg::ST_POR_HOLD || st == rsc_pkg::ST_PH1
			|| st == rsc_pkg::ST_PH2 || st == rsc_pkg::ST_PH3);
	endfunction : drivePinActive

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= rsc_pkg::ST_POR_HOLD;
			kind <= rsc_pkg::K_DRB;
			drivePin <= 1'b1;
			extended <= 1'b0;
			resetLineOut <= 1'b0;
			resetLineOe <= 1'b1;
			runModeEntry <= 1'b0;
			smpsSelfTestStart <= 1'b0;
			status <= rsc_pkg::STATUS_RESET;
		end else begin
			state <= next_state;
			kind <= next_kind;
			drivePin <= next_drivePin;
			extended <= next_extended;
			// Open drain: the pad only ever sees a low value
			resetLineOut <= 1'b0;
			resetLineOe <= next_resetLineOe;
			runModeEntry <= next_runModeEntry;
			smpsSelfTestStart <= next_smpsSelfTestStart;
			status <= next_status;
		end
	end

	// Lower bound falls to the configured length in shortened builds; full builds keep the real minimum
	localparam int unsigned DRB_LO = DRB_CYC < rsc_pkg::DRB_MIN_CYC ? DRB_CYC : rsc_pkg::DRB_MIN_CYC;
	localparam int unsigned DR_LO = DR_CYC < rsc_pkg::DR_MIN_CYC ? DR_CYC : rsc_pkg::DR_MIN_CYC;
	localparam int unsigned ERLB_LO = ERLB_CYC < rsc_pkg::ERLB_MIN_CYC ? ERLB_CYC : rsc_pkg::ERLB_MIN_CYC;
	localparam int unsigned FRL_LO = FRL_CYC < rsc_pkg::FRL_MIN_CYC ? FRL_CYC : rsc_pkg::FRL_MIN_CYC;
	localparam int unsigned FRS_LO = FRS_CYC < rsc_pkg::FRS_MIN_CYC ? FRS_CYC : rsc_pkg::FRS_MIN_CYC;

	// Durations are checked at run mode entry against the elapsed count
	property p_drb_duration;
		@(posedge core_clk) disable iff (rst)
		runModeEntry && kind == rsc_pkg::K_DRB |-> elapsed >= DRB_LO
			&& (extended || elapsed <= rsc_pkg::DRB_MAX_CYC);
	endproperty
	a_drb_duration: assert property (p_drb_duration) else $error("destructive self-test reset duration out of range");

	property p_dr_duration;
		@(posedge core_clk) disable iff (rst)
		runModeEntry && kind == rsc_pkg::K_DR |-> elapsed >= DR_LO
			&& (extended || elapsed <= rsc_pkg::DR_MAX_CYC);
	endproperty
	a_dr_duration: assert property (p_dr_duration) else $error("destructive reset duration out of range");

	property p_erlb_duration;
		@(posedge core_clk) disable iff (rst)
		runModeEntry && kind == rsc_pkg::K_ERLB |-> elapsed >= ERLB_LO
			&& (extended || elapsed <= rsc_pkg::ERLB_MAX_CYC);
	endproperty
	a_erlb_duration: assert property (p_erlb_duration) else $error("external long reset duration out of range");

	property p_frl_duration;
		@(posedge core_clk) disable iff (rst)
		runModeEntry && kind == rsc_pkg::K_FRL |-> elapsed >= FRL_LO
			&& (extended || elapsed <= rsc_pkg::FRL_MAX_CYC);
	endproperty
	a_frl_duration: assert property (p_frl_duration) else $error("functional long reset duration out of range");

	property p_frs_duration;
		@(posedge core_clk) disable iff (rst)
		runModeEntry && kind == rsc_pkg::K_FRS |-> elapsed >= FRS_LO
			&& (extended || elapsed <= rsc_pkg::FRS_MAX_CYC);
	endproperty
	a_frs_duration: assert property (p_frs_duration) else $error("functional short reset duration out of range");

	property p_hold_while_low;
		@(posedge core_clk) disable iff (rst)
		state == rsc_pkg::ST_EXTEND && !resetLineIn && powerOnResetInput_n |=> !runModeEntry && status.inReset;
	endproperty
	a_hold_while_low: assert property (p_hold_while_low) else $error("left reset while line held low");

	property p_run_entry;
		@(posedge core_clk) disable iff (rst)
		$fell(status.inReset) |-> runModeEntry ##1 !runModeEntry;
	endproperty
	a_run_entry: assert property (p_run_entry) else $error("run mode entry not marked on reset exit");

	property p_smps_third;
		@(posedge core_clk) disable iff (rst)
		smpsSelfTestStart |-> status.thirdResetPhase && (kind == rsc_pkg::K_DRB || kind == rsc_pkg::K_DR);
	endproperty
	a_smps_third: assert property (p_smps_third) else $error("regulator self test outside destructive third phase");

	property p_por_start;
		@(posedge core_clk) disable iff (rst)
		state == rsc_pkg::ST_POR_HOLD && powerOnResetInput_n |=> state == rsc_pkg::ST_PH1 && elapsed == rsc_pkg::CNT_RESET;
	endproperty
	a_por_start: assert property (p_por_start) else $error("sequence did not start on power-on-reset release");

	property p_low_only;
		@(posedge core_clk) disable iff (rst)
		resetLineOe |-> !resetLineOut;
	endproperty
	a_low_only: assert property (p_low_only) else $error("reset line driven high");

	property p_func_pin;
		@(posedge core_clk) disable iff (rst)
		(kind == rsc_pkg::K_FRL || kind == rsc_pkg::K_FRS) && !drivePin && powerOnResetInput_n |-> !resetLineOe;
	endproperty
	a_func_pin: assert property (p_func_pin) else $error("functional reset drove line without enable");
endmodule : rsc_reset_sequencer

// File: verif/rsc_partner.sv
// External regulator, reset generator and pull-up on the shared reset line
`timescale 1ns/1ps
module rsc_partner (
	input wire logic porHold,
	input wire logic extHold,
	input wire logic resetLineOut,
	input wire logic resetLineOe,
	output logic powerOnResetInput_n,
	output logic resetLineIn
);
	// Regulator keeps power-on-reset low until the supplies are in range
	assign powerOnResetInput_n = !porHold;
	// Only the pull-up makes a high level; an enabled low driver or the generator pulls low
	assign resetLineIn = ((resetLineOe && !resetLineOut) || extHold) ? 1'b0 : 1'b1;
endmodule : rsc_partner

// File: verif/reset_sequence_control_tb_top.sv
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
module reset_sequence_control_tb_top;
	localparam int T_DRB = 40;
	localparam int T_DR = 20;
	localparam int T_ERLB = 36;
	localparam int T_FRL = 24;
	localparam int T_FRS = 16;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic porHold = 1'b1;
	logic extHold = 1'b0;
	logic bistEnable = 1'b1;
	logic destructiveReq = 1'b0;
	logic functionalReq = 1'b0;
	logic functionalShort = 1'b0;
	logic functionalResetPinEnable = 1'b0;
	logic powerOnResetInput_n;
	logic resetLineIn;
	logic resetLineOut;
	logic resetLineOe;
	logic runModeEntry;
	logic smpsSelfTestStart;
	rsc_pkg::rsc_status_t status;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;

	always #4 core_clk = ~core_clk;

	// Short sequence lengths keep the run small; expectations follow these values
	rsc_reset_sequencer #(.DRB_CYC(T_DRB), .DR_CYC(T_DR), .ERLB_CYC(T_ERLB), .FRL_CYC(T_FRL), .FRS_CYC(T_FRS)) DUT (
		.core_clk(core_clk), .rst(rst), .powerOnResetInput_n(powerOnResetInput_n), .bistEnable(bistEnable),
		.destructiveReq(destructiveReq), .functionalReq(functionalReq), .functionalShort(functionalShort),
		.functionalResetPinEnable(functionalResetPinEnable), .resetLineIn(resetLineIn),
		.resetLineOut(resetLineOut), .resetLineOe(resetLineOe), .runModeEntry(runModeEntry),
		.smpsSelfTestStart(smpsSelfTestStart), .status(status));

	rsc_partner partner (.porHold(porHold), .extHold(extHold), .resetLineOut(resetLineOut),
		.resetLineOe(resetLineOe), .powerOnResetInput_n(powerOnResetInput_n), .resetLineIn(resetLineIn));

	task automatic chkBit(input logic got, input logic exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chkBit

	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t %s got %0d", $time, msg, got);
		end
	endtask : chkVal

	task automatic conclude;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			conclude();
		end
	end

	// Follows one sequence edge by edge; dst says whether the regulator self test must start
	task automatic runSeq(input int tgt, input logic [2:0] k, input logic oeExp, input logic dst, input int holdTo,
		output int cnt);
		cnt = 0;
		do begin
			@(posedge core_clk);
			cnt++;
			destructiveReq <= 1'b0;
			functionalReq <= 1'b0;
			if (cnt == 3 && holdTo > 3) extHold <= 1'b1;
			if (cnt == holdTo) extHold <= 1'b0;
			#1;
			if (cnt == 1) chkVal(status.kind, k, "kind");
			chkBit(resetLineOut, 1'b0, "line driven high");
			chkBit(smpsSelfTestStart, dst && cnt == 9, "self test start");
			chkBit(status.thirdResetPhase, cnt >= 9 && cnt <= tgt, "third phase");
			chkBit(resetLineOe, cnt <= tgt ? oeExp : 1'b0, "line enable");
			if (runModeEntry !== 1'b1) chkBit(status.inReset, 1'b1, "in reset");
		end while (runModeEntry !== 1'b1 && cnt < tgt + holdTo + 8);
		@(posedge core_clk);
		#1;
		chkBit(runModeEntry, 1'b0, "run pulse width");
		chkBit(status.inReset, 1'b0, "run mode");
	endtask : runSeq

	task automatic porStart;
		repeat (3) @(posedge core_clk);
		#1;
		chkBit(status.inReset, 1'b1, "por hold");
		chkBit(runModeEntry, 1'b0, "early run");
		@(posedge core_clk);
		porHold <= 1'b0;
		runSeq(T_DRB, rsc_pkg::K_DRB, 1'b1, 1'b1, 0, n);
		chkVal(n, T_DRB + 2, "por length");
	endtask : porStart

	// Destructive wins over a functional request raised at the same edge
	task automatic destrNoBist;
		@(posedge core_clk);
		bistEnable <= 1'b0;
		destructiveReq <= 1'b1;
		functionalReq <= 1'b1;
		runSeq(T_DR, rsc_pkg::K_DR, 1'b1, 1'b1, 0, n);
		chkVal(n, T_DR + 2, "destructive length");
	endtask : destrNoBist

	task automatic extLong;
		@(posedge core_clk);
		extHold <= 1'b1;
		runSeq(T_ERLB, rsc_pkg::K_ERLB, 1'b1, 1'b0, 1, n);
		chkVal(n, T_ERLB + 2, "external length");
	endtask : extLong

	task automatic funcLong;
		@(posedge core_clk);
		functionalReq <= 1'b1;
		functionalResetPinEnable <= 1'b1;
		runSeq(T_FRL, rsc_pkg::K_FRL, 1'b1, 1'b0, 0, n);
		chkVal(n, T_FRL + 2, "functional long length");
	endtask : funcLong

	task automatic funcShort;
		@(posedge core_clk);
		functionalReq <= 1'b1;
		functionalShort <= 1'b1;
		functionalResetPinEnable <= 1'b0;
		runSeq(T_FRS, rsc_pkg::K_FRS, 1'b0, 1'b0, 0, n);
		chkVal(n, T_FRS + 2, "functional short length");
	endtask : funcShort

	// Generator holds the line low well past the third phase
	task automatic extended;
		@(posedge core_clk);
		functionalReq <= 1'b1;
		runSeq(T_FRS, rsc_pkg::K_FRS, 1'b0, 1'b0, 30, n);
		chkVal(n, 31, "extended length");
	endtask : extended

	task automatic porAbort;
		@(posedge core_clk);
		bistEnable <= 1'b1;
		destructiveReq <= 1'b1;
		@(posedge core_clk);
		destructiveReq <= 1'b0;
		repeat (4) @(posedge core_clk);
		porHold <= 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chkBit(status.inReset, 1'b1, "abort in reset");
		chkBit(resetLineOe, 1'b1, "abort line");
		@(posedge core_clk);
		porHold <= 1'b0;
		runSeq(T_DRB, rsc_pkg::K_DRB, 1'b1, 1'b1, 0, n);
		chkVal(n, T_DRB + 2, "restart length");
	endtask : porAbort

	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		porStart();
		destrNoBist();
		extLong();
		funcLong();
		funcShort();
		extended();
		porAbort();
		conclude();
	end
endmodule : reset_sequence_control_tb_top
